/* File: rtl/axm_pkg.sv */
// Shared constants for the auxiliary converter measurement control block.
// Assumes an 8-bit special-function register bus and a 25 MHz system clock.
package axm_pkg;

	// Register byte addresses on the special-function bus.
	localparam logic [7:0] ADDR_TEMP_RESULT    = 8'hD7;
	localparam logic [7:0] ADDR_CONV_START     = 8'hD8;
	localparam logic [7:0] ADDR_BATT_RESULT    = 8'hDF;
	localparam logic [7:0] ADDR_SUPPLY_RESULT  = 8'hEF;
	localparam logic [7:0] ADDR_DELTA_SELECT   = 8'hF3;
	localparam logic [7:0] ADDR_STROBE_PERIOD  = 8'hF9;
	localparam logic [7:0] ADDR_BATT_THRESHOLD = 8'hFA;

	// Reset values.
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [2:0] RESET_REQ  = 3'h0;

	// Channel indexes; they match the request bit positions.
	localparam int CH_COUNT  = 3;
	localparam int CH_BATT   = 0;
	localparam int CH_TEMP   = 1;
	localparam int CH_SUPPLY = 2;

	// Conversion start register fields.
	localparam int BIT_BATT_REQ   = 0;
	localparam int BIT_TEMP_REQ   = 1;
	localparam int BIT_SUPPLY_REQ = 2;
	localparam int BIT_PLL_ACK    = 7;
	localparam int REQ_WIDTH      = 3;

	// Strobe period register: 2-bit fields, low bit positions.
	localparam int STROBE_TEMP_LSB   = 0;
	localparam int STROBE_BATT_LSB   = 2;
	localparam int STROBE_SUPPLY_LSB = 4;
	localparam logic [7:0] STROBE_MASK = 8'h3F;

	// Delta select register: 3-bit fields, low bit positions.
	localparam int DELTA_SUPPLY_LSB = 0;
	localparam int DELTA_TEMP_LSB   = 3;
	localparam logic [7:0] DELTA_MASK = 8'h3F;

	// Least absolute change, in result codes, that interrupts, per delta code.
	// Code 0 never interrupts and code 7 interrupts on every conversion.
	localparam logic [7:0] SUPPLY_MIN_DIFF [8] = '{8'h00, 8'h01, 8'h01, 8'h01,
		8'h08, 8'h08, 8'h08, 8'h00};
	localparam logic [7:0] TEMP_MIN_DIFF [8] = '{8'h00, 8'h01, 8'h01, 8'h02,
		8'h02, 8'h04, 8'h04, 8'h00};
	localparam logic [2:0] DELTA_OFF    = 3'h0;
	localparam logic [2:0] DELTA_ALWAYS = 3'h7;

	// Background period in minutes per 2-bit code.
	localparam logic [4:0] BATT_MINUTES  [4] = '{5'h00, 5'h10, 5'h04, 5'h01};
	localparam logic [4:0] OTHER_MINUTES [4] = '{5'h00, 5'h08, 5'h02, 5'h01};

	// Timing.
	localparam longint CLOCK_HZ       = 25_000_000;
	localparam longint MINUTE_S       = 60;
	localparam longint MINUTE_CYCLES  = MINUTE_S * CLOCK_HZ;

endpackage : axm_pkg

/* File: rtl/axm_delta_check.sv */
// Change detector comparing a new result against the last interrupting one.
// Assumes both values are 8-bit unsigned converter codes.
`timescale 1ns/1ns
module axm_delta_check #(
	parameter bit IS_TEMP = 1'b0
) (
	input  wire logic [7:0] new_value,
	input  wire logic [7:0] ref_value,
	input  wire logic [2:0] delta_code,
	output logic            exceeded
);
	import axm_pkg::*;

	logic [7:0] abs_diff;
	logic [7:0] min_diff;

	always_comb begin
		abs_diff = (new_value >= ref_value) ? 8'(new_value - ref_value)
			: 8'(ref_value - new_value);
		min_diff = IS_TEMP ? TEMP_MIN_DIFF[delta_code] : SUPPLY_MIN_DIFF[delta_code];
		if (delta_code == DELTA_OFF) begin
			exceeded = 1'b0;
		end else if (delta_code == DELTA_ALWAYS) begin
			exceeded = 1'b1;
		end else begin
			exceeded = (abs_diff >= min_diff);
		end
	end

endmodule : axm_delta_check

/* File: rtl/axm_top.sv */
// Control and result registers for the battery, temperature and supply converters.
// Assumes an 8-bit special-function register bus and converters that
// acknowledge a request, then report a result with a one-cycle done pulse.
`timescale 1ns/1ns

// How it works
// - Supply delta code sets supply change threshold; 0 never, 7 every conversion.
// - Writing one to start bit 7 clears the PLL fault flag.
// - PLL fault flag is set when reset came from PLL lock loss.
// - Writing one to start bit 2 requests one supply conversion.
// - Writing one to start bit 1 requests one temperature conversion.
// - Writing one to start bit 0 requests one battery conversion.
// - Request bits clear once the converter accepts, not at conversion end.
// - Battery result below the threshold register raises an interrupt.
// - Supply result register loads only when its interrupt is raised.
// - Battery result register loads only when its interrupt is raised.
// - Temperature result register loads only when its interrupt is raised.
// - A finished software temperature conversion interrupts and shows its result.
// - Temperature result seen by software is eight bits wide.
// - Temperature delta code sets temperature threshold; 0 never, 7 always.
// - Temperature and supply background results interrupt when change from last interrupting value reaches delta.
// - Two-bit period fields start background conversions every 16, 4 or 1 minutes for battery, every 8, 2 or 1 for the others.
module axm_top #(
	parameter int unsigned MINUTE_CYCLES = 32'(axm_pkg::MINUTE_CYCLES)
) (
	input  wire logic                       clock,
	input  wire logic                       rst,
	input  wire logic [7:0]                 sfr_addr,
	input  wire logic [7:0]                 sfr_wdata,
	input  wire logic                       sfr_write,
	input  wire logic                       sfr_read,
	output logic      [7:0]                 sfr_rdata,
	output logic      [axm_pkg::REQ_WIDTH-1:0] conv_request,
	input  wire logic [axm_pkg::REQ_WIDTH-1:0] conv_accept,
	input  wire logic [axm_pkg::REQ_WIDTH-1:0] conv_done,
	input  wire logic [23:0]                conv_value,
	output logic      [axm_pkg::REQ_WIDTH-1:0] irq_event,
	output logic                            battery_low,
	input  wire logic                       pll_lock_loss,
	output logic                            pll_fault_flag
);
	import axm_pkg::*;

	// Register bus decode.
	// Writes to the read-only result registers and to unmapped addresses decode to nothing,
	// so software cannot disturb a result or the change reference behind it.
	logic       wr_start;
	logic       wr_threshold;
	logic       wr_strobe;
	logic       wr_delta;

	always_comb begin
		wr_start     = sfr_write && (sfr_addr == ADDR_CONV_START);
		wr_threshold = sfr_write && (sfr_addr == ADDR_BATT_THRESHOLD);
		wr_strobe    = sfr_write && (sfr_addr == ADDR_STROBE_PERIOD);
		wr_delta     = sfr_write && (sfr_addr == ADDR_DELTA_SELECT);
	end

	// Configuration registers.
	logic [7:0] threshold_q;
	logic [7:0] threshold_d;
	logic [7:0] strobe_q;
	logic [7:0] strobe_d;
	logic [7:0] delta_q;
	logic [7:0] delta_d;

	// Reserved upper bits of the strobe and delta registers are masked here, so they
	// always read back as zero.
	always_comb begin
		threshold_d = wr_threshold ? sfr_wdata : threshold_q;
		strobe_d    = wr_strobe ? (sfr_wdata & STROBE_MASK) : strobe_q;
		delta_d     = wr_delta ? (sfr_wdata & DELTA_MASK) : delta_q;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			threshold_q <= RESET_BYTE;
			strobe_q    <= RESET_BYTE;
			delta_q     <= RESET_BYTE;
		end else begin
			threshold_q <= threshold_d;
			strobe_q    <= strobe_d;
			delta_q     <= delta_d;
		end
	end

	// PLL fault flag; a new fault wins over a clear in the same cycle.
	logic pll_flag_q;
	logic pll_flag_d;

	always_comb begin
		pll_flag_d = pll_flag_q;
		if (wr_start && sfr_wdata[BIT_PLL_ACK]) begin
			pll_flag_d = 1'b0;
		end
		if (pll_lock_loss) begin
			pll_flag_d = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pll_flag_q <= 1'b0;
		end else begin
			pll_flag_q <= pll_flag_d;
		end
	end

	assign pll_fault_flag = pll_flag_q;

	// Minute prescaler shared by all background timers.
	// It runs from reset and is never restarted, so the first strobe after a period is
	// written may come up to one minute early; later strobes keep the full period.
	logic [31:0] prescale_q;
	logic [31:0] prescale_d;
	logic        minute_tick;

	always_comb begin
		minute_tick = (prescale_q == 32'(MINUTE_CYCLES - 1));
		prescale_d  = minute_tick ? 32'h0000_0000 : 32'(prescale_q + 32'h1);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			prescale_q <= 32'h0000_0000;
		end else begin
			prescale_d_reg: prescale_q <= prescale_d;
		end
	end

	// Per-channel state.
	logic [REQ_WIDTH-1:0] req_q;
	logic [REQ_WIDTH-1:0] req_d;
	logic [REQ_WIDTH-1:0] single_q;
	logic [REQ_WIDTH-1:0] single_d;
	logic [REQ_WIDTH-1:0] irq_q;
	logic [REQ_WIDTH-1:0] irq_d;
	logic [REQ_WIDTH-1:0] background;
	logic [REQ_WIDTH-1:0] exceeded;
	logic [4:0]           minutes_q [REQ_WIDTH];
	logic [4:0]           minutes_d [REQ_WIDTH];
	logic [7:0]           result_q  [REQ_WIDTH];
	logic [7:0]           result_d  [REQ_WIDTH];
	logic                 low_q;
	logic                 low_d;
	logic                 batt_below;

	always_comb begin
		batt_below = (conv_value[8*CH_BATT +: 8] < threshold_q);
	end

	genvar ch;
	generate
		for (ch = 0; ch < CH_COUNT; ch++) begin : g_ch
			localparam int STROBE_LSB = (ch == CH_BATT) ? STROBE_BATT_LSB
				: (ch == CH_TEMP) ? STROBE_TEMP_LSB : STROBE_SUPPLY_LSB;
			logic [1:0] period_code;
			logic [4:0] period_minutes;
			logic       sw_set;
			logic       strobe;
			logic [7:0] value;

			// Background period timer counting whole minutes.
			// A zero period field holds the count at zero, so a period written over a zero field
			// never inherits minutes counted under an earlier setting.
			always_comb begin
				period_code    = strobe_q[STROBE_LSB +: 2];
				period_minutes = (ch == CH_BATT) ? BATT_MINUTES[period_code]
					: OTHER_MINUTES[period_code];
				strobe         = 1'b0;
				minutes_d[ch]  = minutes_q[ch];
				if (period_code == 2'h0) begin
					minutes_d[ch] = 5'h00;
				end else if (minute_tick) begin
					if (5'(minutes_q[ch] + 5'h01) >= period_minutes) begin
						strobe        = 1'b1;
						minutes_d[ch] = 5'h00;
					end else begin
						minutes_d[ch] = 5'(minutes_q[ch] + 5'h01);
					end
				end
			end

			// Request bit, single flag, interrupt and result register.
			// A new start in the accept cycle wins, so a request written while the converter
			// takes the previous one is not lost.
			// The single flag remembers a software start until a done comes back, so that a
			// conversion with no change still interrupts once.
			// The result register is also the change reference, so a conversion that does not
			// interrupt leaves both untouched.
			always_comb begin
				value         = conv_value[8*ch +: 8];
				sw_set        = wr_start && sfr_wdata[ch];
				req_d[ch]     = req_q[ch];
				single_d[ch]  = single_q[ch];
				if (conv_accept[ch]) begin
					req_d[ch] = 1'b0;
				end
				if (sw_set || strobe) begin
					req_d[ch] = 1'b1;
				end
				if (conv_done[ch]) begin
					single_d[ch] = 1'b0;
				end
				if (sw_set) begin
					single_d[ch] = 1'b1;
				end
				if (ch == CH_BATT) begin
					background[ch] = batt_below;
				end else begin
					background[ch] = exceeded[ch];
				end
				irq_d[ch]    = conv_done[ch] && (single_q[ch] || background[ch]);
				result_d[ch] = irq_d[ch] ? value : result_q[ch];
			end

			always_ff @(posedge clock) begin
				if (rst) begin
					req_q[ch]     <= 1'b0;
					single_q[ch]  <= 1'b0;
					irq_q[ch]     <= 1'b0;
					minutes_q[ch] <= 5'h00;
					result_q[ch]  <= RESET_BYTE;
				end else begin
					req_q[ch]     <= req_d[ch];
					single_q[ch]  <= single_d[ch];
					irq_q[ch]     <= irq_d[ch];
					minutes_q[ch] <= minutes_d[ch];
					result_q[ch]  <= result_d[ch];
				end
			end

			// Change detection against the last interrupting result.
			// Battery has no change test; its background condition is the threshold compare.
			if (ch == CH_BATT) begin : g_nodelta
				assign exceeded[ch] = 1'b0;
			end else begin : g_delta
				axm_delta_check #(
					.IS_TEMP (ch == CH_TEMP)
				) u_delta (
					.new_value  (value),
					.ref_value  (result_q[ch]),
					.delta_code ((ch == CH_TEMP) ? delta_q[DELTA_TEMP_LSB +: 3]
						: delta_q[DELTA_SUPPLY_LSB +: 3]),
					.exceeded   (exceeded[ch])
				);
			end
		end
	endgenerate

	// Low battery level follows every battery conversion.
	// It moves whether or not the conversion interrupts, so software sees a fresh level
	// even when the battery result register keeps its old value.
	always_comb begin
		low_d = low_q;
		if (conv_done[CH_BATT]) begin
			low_d = batt_below;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			low_q <= 1'b0;
		end else begin
			low_q <= low_d;
		end
	end

	assign conv_request = req_q;
	assign irq_event    = irq_q;
	assign battery_low  = low_q;

	// Registered read data; unmapped addresses read as zero.
	// Data appears the cycle after the read strobe and stays until the next read, so a
	// slow master may take it late.
	// The start register reads back the pending requests; the acknowledge bit reads zero.
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	always_comb begin
		rdata_d = rdata_q;
		if (sfr_read) begin
			case (sfr_addr)
				ADDR_TEMP_RESULT:    rdata_d = result_q[CH_TEMP];
				ADDR_CONV_START:     rdata_d = {5'h00, req_q};
				ADDR_BATT_RESULT:    rdata_d = result_q[CH_BATT];
				ADDR_SUPPLY_RESULT:  rdata_d = result_q[CH_SUPPLY];
				ADDR_DELTA_SELECT:   rdata_d = delta_q;
				ADDR_STROBE_PERIOD:  rdata_d = strobe_q;
				ADDR_BATT_THRESHOLD: rdata_d = threshold_q;
				default:             rdata_d = RESET_BYTE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_q <= RESET_BYTE;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign sfr_rdata = rdata_q;

endmodule : axm_top

/* File: verif/axm_monitor.sv */
// Assertion checker for the converter control block, bound to its top.
// Assumes the bench leaves the background temperature period at zero.
`timescale 1ns/1ns
module axm_monitor (
	input wire logic                          clock,
	input wire logic                          rst,
	input wire logic [7:0]                    sfr_addr,
	input wire logic [7:0]                    sfr_wdata,
	input wire logic                          sfr_write,
	input wire logic                          sfr_read,
	input wire logic [7:0]                    sfr_rdata,
	input wire logic [axm_pkg::REQ_WIDTH-1:0] conv_request,
	input wire logic [axm_pkg::REQ_WIDTH-1:0] conv_accept,
	input wire logic [axm_pkg::REQ_WIDTH-1:0] conv_done,
	input wire logic [axm_pkg::REQ_WIDTH-1:0] irq_event,
	input wire logic                          pll_lock_loss,
	input wire logic                          pll_fault_flag
);
	import axm_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	logic wr_go;
	logic temp_go;
	assign wr_go   = sfr_write && sfr_addr == ADDR_CONV_START;
	assign temp_go = wr_go && sfr_wdata[1];
	a_temp_req_set: assert property (temp_go |=> conv_request[1])
		else $error("temperature request not raised");
	a_temp_req_hold: assert property (conv_request[1] && !conv_accept[1] |=> conv_request[1])
		else $error("temperature request lost before accept");
	a_temp_req_drop: assert property (conv_request[1] && conv_accept[1] && !temp_go
		|=> !conv_request[1]) else $error("temperature request kept after accept");
	a_req_has_cause: assert property ($rose(conv_request[1]) |-> $past(temp_go))
		else $error("temperature request without a write");
	a_pll_flag_set: assert property (pll_lock_loss |=> pll_fault_flag)
		else $error("fault flag not set");
	a_pll_flag_clear: assert property (wr_go && sfr_wdata[7] && !pll_lock_loss
		|=> !pll_fault_flag) else $error("fault flag not cleared");
	a_irq_after_done: assert property (irq_event != 3'h0
		|-> (irq_event & ~$past(conv_done)) == 3'h0) else $error("interrupt without done");
	a_rdata_holds: assert property (!$past(sfr_read) |-> $stable(sfr_rdata))
		else $error("read data moved without a read");
	a_start_upper_zero: assert property (sfr_read && sfr_addr == ADDR_CONV_START
		|=> sfr_rdata[7:3] == 5'h00) else $error("start register upper bits not zero");
endmodule : axm_monitor

bind axm_top axm_monitor u_mon (.clock, .rst, .sfr_addr, .sfr_wdata, .sfr_write, .sfr_read,
	.sfr_rdata, .conv_request, .conv_accept, .conv_done, .irq_event, .pll_lock_loss,
	.pll_fault_flag);

/* File: verif/axm_top_tb.sv */
// Self-checking bench for the converter control block.
// Assumes this bench plays both the bus master and the three converters.
`timescale 1ns/1ns
module axm_top_tb;
	import axm_pkg::*;
	localparam int MC = 20;
	localparam logic [7:0] RA [3] = '{ADDR_BATT_RESULT, ADDR_TEMP_RESULT, ADDR_SUPPLY_RESULT};
	localparam logic [7:0] AL [8] = '{8'hD7, 8'hD8, 8'hDF, 8'hEF, 8'hF3, 8'hF9, 8'hFA, 8'h00};
	localparam int         TC [9] = '{2, 2, 2, 2, 2, 1, 1, 0, 0};
	localparam logic [7:0] TD [9] = '{8'h04, 8'h04, 8'h01, 8'h07, 8'h00, 8'h18, 8'h18, 8'h00,
		8'h00};
	localparam logic [7:0] TV [9] = '{8'h47, 8'h48, 8'h49, 8'h49, 8'h00, 8'hA6, 8'hA7, 8'h4F,
		8'h50};
	localparam bit         TI [9] = '{0, 1, 1, 1, 0, 0, 1, 1, 0};
	logic        clock, rst, sfr_write, sfr_read, pll_lock_loss, pll_fault_flag, battery_low;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, v;
	logic [7:0]  res [3];
	logic [2:0]  conv_request, conv_accept, conv_done, irq_event;
	logic [23:0] conv_value;
	int          n_fail, total_checks, k, w;
	axm_top #(.MINUTE_CYCLES(MC)) u_dut (.clock, .rst, .sfr_addr, .sfr_wdata, .sfr_write,
		.sfr_read, .sfr_rdata, .conv_request, .conv_accept, .conv_done, .conv_value,
		.irq_event, .battery_low, .pll_lock_loss, .pll_fault_flag);
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_write = 1'b1;
		@(negedge clock);
		sfr_write = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		sfr_addr = a;
		sfr_read = 1'b1;
		@(negedge clock);
		sfr_read = 1'b0;
		d = sfr_rdata;
	endtask : rd
	task automatic wait_req(input int ch, input int lim, output int n);
		n = 0;
		while (conv_request[ch] !== 1'b1) begin
			@(negedge clock);
			n++;
			if (n > lim) begin
				n_fail++;
				$display("Error at %0t: request wait ran out", $time);
				end_of_test();
			end
		end
	endtask : wait_req
	task automatic accept(input int ch);
		wait_req(ch, 8, w);
		conv_accept[ch] = 1'b1;
		@(negedge clock);
		conv_accept[ch] = 1'b0;
		chk(8'(conv_request[ch]), 8'h00);
	endtask : accept
	task automatic done(input int ch, input logic [7:0] val, input bit irq);
		@(negedge clock);
		conv_value[8*ch +: 8] = val;
		conv_done[ch] = 1'b1;
		@(negedge clock);
		conv_done[ch] = 1'b0;
		chk(8'(irq_event[ch]), 8'(irq));
	endtask : done
	initial begin
		rst = 1'b1;
		{sfr_read, sfr_write, pll_lock_loss} = 3'h0;
		{sfr_addr, sfr_wdata} = 16'h0000;
		{conv_accept, conv_done, conv_value} = 30'h0;
		n_fail = 0;
		total_checks = 0;
		repeat (20) @(negedge clock);
		rst = 1'b0;
		chk({4'h0, conv_request, pll_fault_flag}, 8'h00);
		for (k = 0; k < 8; k++) begin
			rd(AL[k], v);
			chk(v, 8'h00);
		end
		$display("Test reset values finished");
		wr(ADDR_CONV_START, 8'h02);
		accept(1);
		rd(ADDR_CONV_START, v);
		chk(v, 8'h00);
		done(1, 8'hA5, 1'b1);
		wr(ADDR_TEMP_RESULT, 8'hFF);
		rd(ADDR_TEMP_RESULT, v);
		chk(v, 8'hA5);
		done(1, 8'h10, 1'b0);
		rd(ADDR_TEMP_RESULT, v);
		chk(v, 8'hA5);
		wr(ADDR_CONV_START, 8'h04);
		accept(2);
		done(2, 8'h40, 1'b1);
		wr(ADDR_BATT_THRESHOLD, 8'h50);
		rd(ADDR_BATT_THRESHOLD, v);
		chk(v, 8'h50);
		wr(ADDR_CONV_START, 8'h01);
		accept(0);
		done(0, 8'h60, 1'b1);
		chk(8'(battery_low), 8'h00);
		res = '{8'h60, 8'hA5, 8'h40};
		$display("Test single conversions finished");
		for (k = 0; k < 9; k++) begin
			wr(ADDR_DELTA_SELECT, TD[k]);
			done(TC[k], TV[k], TI[k]);
			if (TC[k] == CH_BATT) chk(8'(battery_low), 8'(TV[k] < 8'h50));
			if (TI[k]) res[TC[k]] = TV[k];
			rd(RA[TC[k]], v);
			chk(v, res[TC[k]]);
		end
		$display("Test change thresholds finished");
		@(negedge clock);
		pll_lock_loss = 1'b1;
		@(negedge clock);
		pll_lock_loss = 1'b0;
		chk(8'(pll_fault_flag), 8'h01);
		wr(ADDR_CONV_START, 8'h80);
		chk({4'h0, conv_request, pll_fault_flag}, 8'h00);
		$display("Test fault flag finished");
		wr(ADDR_STROBE_PERIOD, 8'h0C);
		wait_req(0, MC + 3, k);
		accept(0);
		wait_req(0, MC + 3, k);
		chk(8'(k), 8'(MC - 1));
		wr(ADDR_STROBE_PERIOD, 8'h00);
		accept(0);
		$display("Test background period finished");
		end_of_test();
	end
endmodule : axm_top_tb
